// ### rtl/uartc_pkg.sv
// Package for the serial transmit/receive core: register map, field
// positions, reset values and timing constants.
// Assumes a 100 MHz system clock and an Avalon-MM slave with 32-bit data.
// Overview of operation
// - Receiver runs when either receive-enable bit is set, stops when both clear.
// - Word-length setting picks 7 or 8 data bits for both directions.
// - Parity enabled adds a parity bit on transmit and checks it on receive.
// - Parity-mode setting picks odd or even for generation and checking.
// - Receive-invert flips the incoming line, transmit-invert the outgoing line.
// - Echo mode drives transmit line from receive line XOR transmit-invert.
// - Writing transmit data sets transmit-full; sending needs transmit enable.
// - After previous word finishes, holding word loads shifter and clears full.
// - Transmit interrupt pulses on each falling edge of transmit-full.
// - Transmit-busy reads one while a word is shifted out.
// - Data bits leave least significant bit first.
// - Receive-busy sets as soon as a start bit is detected.
// - At stop bit, word moves to receive data, full sets, interrupt pulses.
// - Reading receive data clears full; transfer while full sets overrun.
// - Any write to receive status clears the overrun flag.
// - Start-error flag is updated only when a word is transferred.
// - Parity-error flag set on mismatch, updated at word transfer.
// - Frame-error flag set when stop-bit position is not high.
// - Parity-mode zero selects odd parity, one selects even parity.
// - Word-length one selects 8 bits, zero selects 7; resets to one.
package uartc_pkg;
   localparam logic [3:0] UARTC_OFS_CMD = 4'h0;
   localparam logic [3:0] UARTC_OFS_CTRL = 4'h4;
   localparam logic [3:0] UARTC_OFS_TX = 4'h8;
   localparam logic [3:0] UARTC_OFS_TXSTA = 4'hc;
   localparam logic [3:0] UARTC_ADDR_W_DUMMY = 4'h0;
   localparam logic [5:0] UARTC_OFS_RX = 6'h10;
   localparam logic [5:0] UARTC_OFS_RXSTA = 6'h14;
   localparam logic [7:0] UARTC_CMD_RST = 8'h01;
   localparam logic [7:0] UARTC_CTRL_RST = 8'h05;
   // Command register fields
   localparam int UARTC_CMD_XTAL = 7;
   localparam int UARTC_CMD_ENRX_B = 6;
   localparam int UARTC_CMD_PM = 2;
   localparam int UARTC_CMD_PE = 1;
   localparam int UARTC_CMD_WL = 0;
   // Control register fields
   localparam int UARTC_CTRL_ECHO = 7;
   localparam int UARTC_CTRL_ENRX_A = 6;
   localparam int UARTC_CTRL_ENTX = 5;
   localparam int UARTC_CTRL_XRX = 4;
   localparam int UARTC_CTRL_XTX = 3;
   // Default bit period
   localparam int UARTC_CLK_HZ = 100000000;
   localparam int UARTC_BAUD = 115200;
   localparam int UARTC_BIT_CYC = UARTC_CLK_HZ / UARTC_BAUD;

   typedef struct packed {
      logic echo_enable;
      logic tx_enable_bit;
      logic rx_line_invert;
      logic tx_line_invert;
      logic word_length_sel;
      logic parity_enable;
      logic parity_mode_sel;
      logic rx_on;
   } uartc_cfg_t;

   typedef enum logic [4:0] {
      UARTC_IDLE = 5'b00001,
      UARTC_START = 5'b00010,
      UARTC_DATA = 5'b00100,
      UARTC_PAR = 5'b01000,
      UARTC_STOP = 5'b10000
   } uartc_state_t;
endpackage

// ### rtl/uartc_core.sv
// Serial transmitter and receiver with holding registers and status.
// Registers reached over Avalon-MM; answers one cycle after a request.
module uartc_core import uartc_pkg::*; #(
   parameter int BIT_CYC = UARTC_BIT_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [5:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [31:0] i_writedata,
   input wire logic [3:0] i_byteenable,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   input wire logic i_rx,
   output logic o_tx,
   output logic o_irq_tx,
   output logic o_irq_rx,
   output logic [2:0] o_baud_select,
   output logic [2:0] o_rc_prescaler_select,
   output logic o_crystal_clock_select
);
   logic [7:0] serial_command_reg;
   logic [7:0] serial_control_reg;
   logic [7:0] tx_data_reg;
   logic [7:0] rx_data_reg;
   logic tx_holding_full, tx_shifting;
   logic rx_holding_full, rx_shifting;
   logic rx_overrun_flag, rx_start_err_flag;
   logic rx_parity_err_flag, rx_frame_err_flag;
   logic ack;
   uartc_cfg_t cfg;
   logic wr_go, rd_go, lo_en;

   assign lo_en = i_byteenable[0];
   assign wr_go = i_write && !ack;
   assign rd_go = i_read && !ack;
   assign cfg.echo_enable = serial_control_reg[UARTC_CTRL_ECHO];
   assign cfg.tx_enable_bit = serial_control_reg[UARTC_CTRL_ENTX];
   assign cfg.rx_line_invert = serial_control_reg[UARTC_CTRL_XRX];
   assign cfg.tx_line_invert = serial_control_reg[UARTC_CTRL_XTX];
   assign cfg.word_length_sel = serial_command_reg[UARTC_CMD_WL];
   assign cfg.parity_enable = serial_command_reg[UARTC_CMD_PE];
   assign cfg.parity_mode_sel = serial_command_reg[UARTC_CMD_PM];
   assign cfg.rx_on = serial_control_reg[UARTC_CTRL_ENRX_A] |
      serial_command_reg[UARTC_CMD_ENRX_B];

   // Bus handshake: waitrequest high until the cycle that answers
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ack <= 1'b0;
      end else begin
         ack <= (i_read || i_write) && !ack;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_waitrequest <= 1'b1;
      end else begin
         o_waitrequest <= !((i_read || i_write) && !ack);
      end
   end

   // Configuration registers
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         serial_command_reg <= UARTC_CMD_RST;
         serial_control_reg <= UARTC_CTRL_RST;
      end else if (wr_go && lo_en) begin
         if (i_address == {2'b00, UARTC_OFS_CMD}) begin
            serial_command_reg <= i_writedata[7:0];
         end else if (i_address == {2'b00, UARTC_OFS_CTRL}) begin
            serial_control_reg <= i_writedata[7:0];
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_baud_select <= 3'h5;
         o_rc_prescaler_select <= 3'h0;
         o_crystal_clock_select <= 1'b0;
      end else begin
         o_baud_select <= serial_control_reg[2:0];
         o_rc_prescaler_select <= serial_command_reg[5:3];
         o_crystal_clock_select <= serial_command_reg[UARTC_CMD_XTAL];
      end
   end

   // ---------------- Transmitter ----------------
   uartc_state_t tx_state;
   logic [15:0] tx_cnt;
   logic [2:0] tx_idx;
   logic [7:0] tx_shift;
   logic tx_par, tx_line, tx_load, tx_tick;
   logic [2:0] last_idx;

   assign last_idx = cfg.word_length_sel ? 3'h7 : 3'h6;
   assign tx_tick = (tx_cnt == 16'(BIT_CYC - 1));
   assign tx_load = tx_holding_full && cfg.tx_enable_bit &&
      (tx_state == UARTC_IDLE);

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tx_data_reg <= 8'h00;
         tx_holding_full <= 1'b0;
      end else begin
         if (wr_go && lo_en && i_address == {2'b00, UARTC_OFS_TX}) begin
            tx_data_reg <= i_writedata[7:0];
            tx_holding_full <= 1'b1;
         end else if (tx_load) begin
            tx_holding_full <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tx_state <= UARTC_IDLE;
         tx_cnt <= 16'h0000;
         tx_idx <= 3'h0;
         tx_shift <= 8'h00;
         tx_par <= 1'b0;
         tx_line <= 1'b1;
      end else begin
         tx_cnt <= (tx_state == UARTC_IDLE || tx_tick) ? 16'h0000 :
            tx_cnt + 16'h0001;
         case (tx_state)
            UARTC_IDLE: begin
               tx_line <= 1'b1;
               if (tx_load) begin
                  tx_shift <= tx_data_reg;
                  tx_par <= ~cfg.parity_mode_sel;
                  tx_idx <= 3'h0;
                  tx_line <= 1'b0;
                  tx_state <= UARTC_START;
               end
            end
            UARTC_START: begin
               if (tx_tick) begin
                  tx_line <= tx_shift[0];
                  tx_par <= tx_par ^ tx_shift[0];
                  tx_state <= UARTC_DATA;
               end
            end
            UARTC_DATA: begin
               if (tx_tick) begin
                  tx_shift <= {1'b0, tx_shift[7:1]};
                  tx_idx <= tx_idx + 3'h1;
                  if (tx_idx == last_idx) begin
                     if (cfg.parity_enable) begin
                        tx_line <= tx_par;
                        tx_state <= UARTC_PAR;
                     end else begin
                        tx_line <= 1'b1;
                        tx_state <= UARTC_STOP;
                     end
                  end else begin
                     tx_line <= tx_shift[1];
                     tx_par <= tx_par ^ tx_shift[1];
                  end
               end
            end
            UARTC_PAR: begin
               if (tx_tick) begin
                  tx_line <= 1'b1;
                  tx_state <= UARTC_STOP;
               end
            end
            UARTC_STOP: begin
               if (tx_tick) begin
                  tx_state <= UARTC_IDLE;
               end
            end
            default: tx_state <= UARTC_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tx_shifting <= 1'b0;
         o_irq_tx <= 1'b0;
         o_tx <= 1'b1;
      end else begin
         tx_shifting <= (tx_state != UARTC_IDLE) || tx_load;
         o_irq_tx <= tx_load;
         o_tx <= (cfg.echo_enable ? i_rx : tx_line) ^
            cfg.tx_line_invert;
      end
   end

   // ---------------- Receiver ----------------
   uartc_state_t rx_state;
   logic [15:0] rx_cnt;
   logic [2:0] rx_idx;
   logic [7:0] rx_shift;
   logic rx_par, rx_bit, rx_mid, rx_serr, rx_done;
   logic rx_perr, rx_ferr, rx_rd;

   assign rx_bit = i_rx ^ cfg.rx_line_invert;
   assign rx_mid = (rx_cnt == 16'(BIT_CYC / 2));
   assign rx_rd = rd_go && i_address == UARTC_OFS_RX;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rx_state <= UARTC_IDLE;
         rx_cnt <= 16'h0000;
         rx_idx <= 3'h0;
         rx_shift <= 8'h00;
         rx_par <= 1'b0;
         rx_serr <= 1'b0;
         rx_perr <= 1'b0;
         rx_ferr <= 1'b0;
         rx_done <= 1'b0;
      end else begin
         rx_done <= 1'b0;
         rx_cnt <= (rx_state == UARTC_IDLE ||
            rx_cnt == 16'(BIT_CYC - 1)) ? 16'h0000 : rx_cnt + 16'h0001;
         if (!cfg.rx_on) begin
            rx_state <= UARTC_IDLE;
         end else begin
            case (rx_state)
               UARTC_IDLE: begin
                  if (!rx_bit) begin
                     rx_state <= UARTC_START;
                     rx_idx <= 3'h0;
                     rx_shift <= 8'h00;
                     rx_par <= ~cfg.parity_mode_sel;
                  end
               end
               UARTC_START: begin
                  if (rx_mid) begin
                     rx_serr <= rx_bit;
                     rx_state <= UARTC_DATA;
                  end
               end
               UARTC_DATA: begin
                  if (rx_mid) begin
                     rx_shift[rx_idx] <= rx_bit;
                     rx_par <= rx_par ^ rx_bit;
                     rx_idx <= rx_idx + 3'h1;
                     if (rx_idx == last_idx) begin
                        rx_state <= cfg.parity_enable ? UARTC_PAR :
                           UARTC_STOP;
                     end
                  end
               end
               UARTC_PAR: begin
                  if (rx_mid) begin
                     rx_perr <= rx_par ^ rx_bit;
                     rx_state <= UARTC_STOP;
                  end
               end
               UARTC_STOP: begin
                  if (rx_mid) begin
                     if (!cfg.parity_enable) begin
                        rx_perr <= 1'b0;
                     end
                     rx_ferr <= !rx_bit;
                     rx_done <= 1'b1;
                     rx_state <= UARTC_IDLE;
                  end
               end
               default: rx_state <= UARTC_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rx_data_reg <= 8'h00;
         rx_holding_full <= 1'b0;
         rx_overrun_flag <= 1'b0;
         rx_start_err_flag <= 1'b0;
         rx_parity_err_flag <= 1'b0;
         rx_frame_err_flag <= 1'b0;
         o_irq_rx <= 1'b0;
         rx_shifting <= 1'b0;
      end else begin
         rx_shifting <= cfg.rx_on && (rx_state != UARTC_IDLE ||
            !rx_bit) && !(rx_state == UARTC_STOP && rx_mid);
         o_irq_rx <= rx_done;
         if (rx_done) begin
            rx_data_reg <= rx_shift;
            rx_holding_full <= 1'b1;
            rx_start_err_flag <= rx_serr;
            rx_parity_err_flag <= rx_perr;
            rx_frame_err_flag <= rx_ferr;
         end else if (rx_rd) begin
            rx_holding_full <= 1'b0;
         end
         if (rx_done && rx_holding_full && !rx_rd) begin
            rx_overrun_flag <= 1'b1;
         end else if (wr_go && i_address == UARTC_OFS_RXSTA) begin
            rx_overrun_flag <= 1'b0;
         end
      end
   end

   // Read data mux; unmapped addresses read zero
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_readdata <= 32'h0000_0000;
      end else if (rd_go) begin
         if (i_address == {2'b00, UARTC_OFS_CMD}) begin
            o_readdata <= {24'h000000, serial_command_reg};
         end else if (i_address == {2'b00, UARTC_OFS_CTRL}) begin
            o_readdata <= {24'h000000, serial_control_reg};
         end else if (i_address == {2'b00, UARTC_OFS_TX}) begin
            o_readdata <= {24'h000000, tx_data_reg};
         end else if (i_address == {2'b00, UARTC_OFS_TXSTA}) begin
            o_readdata <= {30'h0, tx_shifting, tx_holding_full};
         end else if (i_address == UARTC_OFS_RX) begin
            o_readdata <= {24'h000000, rx_data_reg};
         end else if (i_address == UARTC_OFS_RXSTA) begin
            o_readdata <= {26'h0, rx_start_err_flag, rx_parity_err_flag,
               rx_frame_err_flag, rx_overrun_flag, rx_shifting,
               rx_holding_full};
         end else begin
            o_readdata <= 32'h0000_0000;
         end
      end else begin
         o_readdata <= 32'h0000_0000;
      end
   end
endmodule

// ### sim/uartc_core_monitor.sv
// Checker for the serial core: bus answers, pulses, echo and bit time.
// Sees only the core's ports; bound into every uartc_core.
module uartc_core_monitor import uartc_pkg::*; #(
   parameter int BIT_CYC = UARTC_BIT_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [5:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [31:0] i_writedata,
   input wire logic [3:0] i_byteenable,
   input wire logic [31:0] o_readdata,
   input wire logic o_waitrequest,
   input wire logic i_rx,
   input wire logic o_tx,
   input wire logic o_irq_tx,
   input wire logic o_irq_rx
);
   logic [7:0] ctrl_sh;
   logic tx_q;
   logic plain;
   int run;
   assign plain = !ctrl_sh[7] && !ctrl_sh[3];
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl_sh <= UARTC_CTRL_RST;
      end else if (i_write && !o_waitrequest && i_byteenable[0] &&
                   i_address == {2'b00, UARTC_OFS_CTRL}) begin
         ctrl_sh <= i_writedata[7:0];
      end
   end
   // Cycles spent at the present transmit level
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tx_q <= 1'b1;
         run <= 0;
      end else begin
         tx_q <= o_tx;
         run <= (o_tx != tx_q) ? 1 : run + 1;
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   a_ack_latency: assert property ((i_read || i_write) && o_waitrequest
      |=> !o_waitrequest) else $error("request not answered");
   a_ack_single: assert property (!o_waitrequest |=> o_waitrequest)
      else $error("answer longer than one cycle");
   a_no_spurious: assert property (!(i_read || i_write) && o_waitrequest
      |=> o_waitrequest) else $error("answer without request");
   a_rdata_idle: assert property (o_waitrequest |-> o_readdata == '0)
      else $error("read data outside answer");
   a_rdata_width: assert property (i_read && !o_waitrequest
      |-> o_readdata[31:8] == '0) else $error("upper read bits set");
   a_unmapped_rd: assert property (i_read && !o_waitrequest &&
      i_address > 6'h14 |-> o_readdata == '0) else $error("unmapped read");
   a_irq_tx_pulse: assert property (o_irq_tx |=> !o_irq_tx)
      else $error("tx interrupt not a pulse");
   a_irq_rx_pulse: assert property (o_irq_rx |=> !o_irq_rx)
      else $error("rx interrupt not a pulse");
   a_echo_follow: assert property (ctrl_sh[7] && $rose(i_rx)
      |-> ##[1:4] (o_tx == !ctrl_sh[3])) else $error("echo not followed");
   a_tx_bit_time: assert property (o_tx && !tx_q && plain &&
      $past(plain, 3) |-> run % BIT_CYC == 0) else $error("bad bit time");
endmodule

bind uartc_core uartc_core_monitor #(.BIT_CYC(BIT_CYC)) u_mon (
   .i_clk(i_clk), .i_rst_n(i_rst_n), .i_address(i_address),
   .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
   .i_byteenable(i_byteenable), .o_readdata(o_readdata),
   .o_waitrequest(o_waitrequest), .i_rx(i_rx), .o_tx(o_tx),
   .o_irq_tx(o_irq_tx), .o_irq_rx(o_irq_rx));

// ### sim/uartc_remote.sv
// Remote serial device: sends framed words, decodes the core's output.
// Assumes the bench sets nbits and pe before each decoded transfer.
module uartc_remote #(
   parameter int BIT_CYC = 16
) (
   input wire logic i_clk,
   input wire logic i_txd,
   output logic o_rxd
);
   timeunit 1ns;
   timeprecision 1ps;
   int nbits = 8;
   logic pe = 1'b0;
   logic [8:0] got[$];
   logic [8:0] word;
   initial o_rxd = 1'b1;
   task automatic put(input logic b, input logic inv);
      o_rxd <= b ^ inv;
      repeat (BIT_CYC) @(posedge i_clk);
   endtask
   task automatic idle(input logic inv);
      o_rxd <= ~inv;
   endtask
   task automatic send(input logic [7:0] d, input int n, input logic p_en,
                       input logic p, input logic stop, input logic inv);
      put(1'b0, inv);
      for (int i = 0; i < n; i++) put(d[i], inv);
      if (p_en) put(p, inv);
      put(stop, inv);
      if (!stop) o_rxd <= ~inv;
   endtask
   // Decoder: only well-framed words are kept
   always begin
      @(negedge i_txd);
      repeat (BIT_CYC / 2) @(posedge i_clk);
      word = '0;
      for (int i = 0; i < nbits; i++) begin
         repeat (BIT_CYC) @(posedge i_clk);
         word[i] = i_txd;
      end
      if (pe) begin
         repeat (BIT_CYC) @(posedge i_clk);
         word[8] = i_txd;
      end
      repeat (BIT_CYC) @(posedge i_clk);
      if (i_txd) got.push_back(word);
   end
endmodule

// ### sim/tb.sv
// Bench for the serial core: register bus master plus remote device.
// Assumes the core answers over Avalon-MM and runs with BIT_CYC 16.
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
   $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import uartc_pkg::*;
   localparam int BC = 16;
   logic i_clk = 0, i_rst_n = 0, i_read = 0, i_write = 0;
   logic [5:0] i_address = '0;
   logic [31:0] i_writedata = '0;
   logic [3:0] i_byteenable = 4'h1;
   logic [31:0] o_readdata, q;
   logic o_waitrequest, i_rx, o_tx, o_irq_tx, o_irq_rx;
   logic [2:0] baud_sel, rc_sel;
   logic xtal_sel;
   int fails = 0, num_checks = 0, cyc = 0, nrx = 0;
   uartc_core #(.BIT_CYC(BC)) u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_address(i_address), .i_read(i_read), .i_write(i_write),
      .i_writedata(i_writedata), .i_byteenable(i_byteenable),
      .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
      .i_rx(i_rx), .o_tx(o_tx), .o_irq_tx(o_irq_tx), .o_irq_rx(o_irq_rx),
      .o_baud_select(baud_sel), .o_rc_prescaler_select(rc_sel),
      .o_crystal_clock_select(xtal_sel));
   uartc_remote #(.BIT_CYC(BC)) u_rem (.i_clk(i_clk), .i_txd(o_tx),
      .o_rxd(i_rx));
   initial forever #5 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      cyc++;
      if (o_irq_rx === 1'b1) nrx++;
      if (cyc == 20000) begin
         fails++;
         results();
      end
   end
   task results;
      if (fails == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic bus(input logic wr, input logic [5:0] a,
                      input logic [7:0] d);
      int n;
      n = 0;
      @(posedge i_clk);
      i_address <= a;
      i_writedata <= {24'h0, d};
      i_write <= wr;
      i_read <= !wr;
      do @(posedge i_clk); while (o_waitrequest && ++n < 50);
      if (n >= 50) fails++;
      q = o_readdata;
      i_write <= 1'b0;
      i_read <= 1'b0;
   endtask
   task automatic t_tx(input logic [7:0] cmd, d0, d1);
      logic [7:0] m;
      logic [8:0] e0, e1;
      int n;
      m = cmd[0] ? 8'hff : 8'h7f;
      e0 = {cmd[1] & (^(d0 & m) ^ ~cmd[2]), d0 & m};
      e1 = {cmd[1] & (^(d1 & m) ^ ~cmd[2]), d1 & m};
      u_rem.nbits = cmd[0] ? 8 : 7;
      u_rem.pe = cmd[1];
      u_rem.got.delete();
      bus(1'b1, 6'h00, cmd);
      bus(1'b1, 6'h04, 8'h20);
      bus(1'b1, 6'h08, d0);
      n = 0;
      while (o_irq_tx !== 1'b1 && n++ < 200) @(posedge i_clk);
      if (o_irq_tx !== 1'b1) fails++;
      bus(1'b0, 6'h0c, 8'h00);
      `CHK(q[7:0], 8'h02);
      bus(1'b1, 6'h08, d1);
      bus(1'b0, 6'h0c, 8'h00);
      `CHK(q[7:0], 8'h03);
      repeat (30 * BC) @(posedge i_clk);
      `CHK(u_rem.got.size(), 2);
      `CHK(u_rem.got[0], e0);
      `CHK(u_rem.got[1], e1);
   endtask
   task automatic t_rx(input logic [7:0] cmd, ctrl, d,
                       input logic badp, stop, input logic [7:0] sta);
      logic [7:0] m;
      m = cmd[0] ? 8'hff : 8'h7f;
      bus(1'b1, 6'h00, 8'h00);
      bus(1'b1, 6'h04, 8'h00);
      u_rem.idle(ctrl[4]);
      bus(1'b1, 6'h04, ctrl);
      bus(1'b1, 6'h00, cmd);
      fork
         u_rem.send(d, cmd[0] ? 8 : 7, cmd[1],
                    ^(d & m) ^ ~cmd[2] ^ badp, stop, ctrl[4]);
         begin
            repeat (3 * BC) @(posedge i_clk);
            bus(1'b0, UARTC_OFS_RXSTA, 8'h00);
            `CHK(q[1], sta[0]);
         end
      join
      // A low stop bit looks like a new start; abort that false frame
      if (!stop) bus(1'b1, 6'h00, cmd & 8'hbf);
      repeat (BC) @(posedge i_clk);
      bus(1'b0, UARTC_OFS_RXSTA, 8'h00);
      `CHK(q[7:0], sta);
      bus(1'b0, UARTC_OFS_RX, 8'h00);
      if (sta[0]) `CHK(q[7:0], d & m);
      bus(1'b0, UARTC_OFS_RXSTA, 8'h00);
      `CHK(q[7:0], sta & 8'hfe);
   endtask
   task automatic t_ovr;
      int n0;
      bus(1'b1, 6'h00, 8'h41);
      n0 = nrx;
      u_rem.send(8'h12, 8, 1'b0, 1'b0, 1'b1, 1'b0);
      u_rem.send(8'h34, 8, 1'b0, 1'b0, 1'b1, 1'b0);
      repeat (BC) @(posedge i_clk);
      `CHK(nrx - n0, 2);
      bus(1'b0, UARTC_OFS_RXSTA, 8'h00);
      `CHK(q[7:0], 8'h05);
      bus(1'b0, UARTC_OFS_RX, 8'h00);
      `CHK(q[7:0], 8'h34);
      bus(1'b1, UARTC_OFS_RXSTA, 8'h5a);
      bus(1'b0, UARTC_OFS_RXSTA, 8'h00);
      `CHK(q[7:0], 8'h00);
   endtask
   task automatic t_echo;
      u_rem.nbits = 8;
      u_rem.pe = 1'b0;
      u_rem.got.delete();
      bus(1'b1, 6'h04, 8'h80);
      u_rem.send(8'h96, 8, 1'b0, 1'b0, 1'b1, 1'b0);
      repeat (2 * BC) @(posedge i_clk);
      `CHK(u_rem.got.size(), 1);
      `CHK(u_rem.got[0], 9'h096);
      bus(1'b1, 6'h04, 8'h08);
      repeat (4) @(posedge i_clk);
      `CHK(o_tx, 1'b0);
   endtask
   initial begin
      repeat (12) @(posedge i_clk);
      i_rst_n <= 1'b1;
      bus(1'b1, 6'h20, 8'hff);
      bus(1'b0, 6'h00, 8'h00);
      `CHK(q[7:0], UARTC_CMD_RST);
      bus(1'b0, 6'h04, 8'h00);
      `CHK(q[7:0], UARTC_CTRL_RST);
      `CHK({xtal_sel, rc_sel, baud_sel}, 7'h05);
      for (int i = 0; i < 4; i++) begin
         bus(1'b0, 6'h0c + 6'(i * 4), 8'h00);
         `CHK(q, 32'h0);
      end
      bus(1'b0, 6'h3c, 8'h00);
      `CHK(q, 32'h0);
      t_tx(8'h01, 8'ha5, 8'h3c);
      `CHK({xtal_sel, rc_sel, baud_sel}, 7'h00);
      t_tx(8'h03, 8'h96, 8'h01);
      t_tx(8'h06, 8'h5b, 8'h7f);
      t_tx(8'h00, 8'hc1, 8'h2e);
      t_rx(8'h01, 8'h00, 8'ha5, 1'b0, 1'b1, 8'h00);
      t_rx(8'h01, 8'h40, 8'ha5, 1'b0, 1'b1, 8'h01);
      t_rx(8'h47, 8'h00, 8'h3c, 1'b0, 1'b1, 8'h01);
      t_rx(8'h42, 8'h10, 8'hdb, 1'b0, 1'b1, 8'h01);
      t_rx(8'h43, 8'h40, 8'h66, 1'b1, 1'b1, 8'h11);
      t_rx(8'h41, 8'h00, 8'h99, 1'b0, 1'b0, 8'h09);
      t_ovr();
      t_echo();
      results();
   end
endmodule
